// File: rtl/ilpm_map.vh
// Purpose: constants for the interrupt level priority and masking block
// Assumes: included by rtl/ilpm_ctrl.v
// Notes: level codes double as winner encoding
`ifndef ILPM_MAP_VH
`define ILPM_MAP_VH
// winner level codes, priority rank order
`define ILPM_LVL_NONE 4'h0
`define ILPM_LVL_MCX 4'h1
`define ILPM_LVL_MCA 4'h2
`define ILPM_LVL_PGM 4'h3
`define ILPM_LVL_SVC 4'h4
`define ILPM_LVL_PER 4'h5
`define ILPM_LVL_MCR 4'h6
`define ILPM_LVL_TMR 4'h7
`define ILPM_LVL_IOT 4'h8
// old/new status word pair area bases
`define ILPM_PAIR_MC 12'h030
`define ILPM_PAIR_PGM 12'h040
`define ILPM_PAIR_SVC 12'h050
`define ILPM_PAIR_TMR 12'h060
`define ILPM_PAIR_IOT 12'h020
`define ILPM_PAIR_PER 12'h080
// event identification area
`define ILPM_PER_ID_LO 12'h1f0
`define ILPM_PER_ID_HI 12'h1f7
// cause code field in old status word
`define ILPM_CODE_LSB 24
`define ILPM_CODE_MSB 31
`define ILPM_CODE_TMR 8'h60
`define ILPM_CODE_ZERO 8'h00
// machine check cause bits in code
`define ILPM_MCC_FAULT 0
`define ILPM_MCC_ABN 1
`define ILPM_MCC_ALARM 2
`define ILPM_MCC_TDF 3
`define ILPM_MCC_TCW 4
// program exception classes
`define ILPM_PX_CLASSES 16
`define ILPM_PX_FXOVF 4'h8
`define ILPM_PX_DECOVF 4'ha
`define ILPM_PX_EXPUNF 4'hd
`define ILPM_PX_SIGNIF 4'he
// program mask bit positions
`define ILPM_PM_FX 3
`define ILPM_PM_DEC 2
`define ILPM_PM_EXP 1
`define ILPM_PM_SIG 0
`endif

// File: rtl/ilpm_ctrl.v
// Purpose: interrupt request collection, masking and priority selection
// Assumes: all request inputs synchronous one-cycle pulses on clock
// Notes: entry sequence itself is outside; this block hands it a winner
// Operation
// [R1] fault with mask clear: immediate exigent entry
// [R2] alarm with both masks clear: after instruction
// [R3] exception with exception mask set escalates
// [R4] tabler data fault: repressible check after instruction
// [R5] tabler word access fault: repressible check
// [R6] repressible cause reported with other causes
// [R7] sixteen exception classes, own codes
// [R8] supervisor call never masked
// [R9] timer edge depends on model variant
// [R10] timer taken only with timer mask
// [R11] tabler request on completion or error
// [R12] tabler taken only with its mask
// [R13] event recording needs enables, id area
// [R14] set hardware mask holds or escalates
// [R15] unmasked requests accepted at once
// [R16] four program mask bits gate exceptions
// [R17] request flip-flop per level, arbitrated
// [R18] entry done clears requests, new masks
// [R19] fixed priority ranks one to eight
// [R20] each level own status word pair; the three machine check levels share ILPM_PAIR_MC
// [R21] taking exception sets exception mask
// [R22] check with check mask set stops
// [R23] save status word with cause code
// [R24] ranks one to four mutually exclusive
// [R25] reset clears requests and masks
// [R26] arbitrate at boundaries except exigent
`include "ilpm_map.vh"
module ilpm_ctrl #(
  parameter MODEL_POS_TO_ZERO = 0,
  parameter TMR_W = 24
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // machine check sources
  input wire hw_fault,
  input wire hw_alarm,
  input wire tabler_data_fault,
  input wire tabler_control_word_fault,
  // program exception source
  input wire prog_exc,
  input wire [3:0] prog_exc_class,
  // supervisor call
  input wire supervisor_call,
  input wire [7:0] supervisor_call_code,
  // interval timer count, sampled each cycle
  input wire [TMR_W-1:0] timer_count,
  // io status tabler events
  input wire io_status_tabler_done,
  input wire io_status_tabler_error,
  // event trace recording
  input wire event_trace_hit,
  input wire event_trace_cr_en,
  // current status word masks
  input wire psw_timer_mask,
  input wire psw_tabler_mask,
  input wire psw_event_mask,
  input wire [3:0] psw_program_mask,
  input wire [31:0] cur_program_status_word,
  // sequencer handshake
  input wire instr_boundary,
  input wire entry_done,
  input wire mask_clear_load,
  // entry request to sequencer
  output wire entry_req,
  output wire entry_preempt,
  output reg [3:0] entry_level,
  output reg [11:0] entry_pair_addr,
  output reg [31:0] old_status_word,
  output reg event_id_store,
  output wire [11:0] event_id_lo,
  output wire [11:0] event_id_hi,
  // status
  output reg hw_fault_mask,
  output reg prog_exception_mask,
  output reg check_stop,
  output wire [8:1] pending
);
  reg [8:1] req_r;
  reg [8:1] req_nxt;
  reg [4:0] mc_cause_r;
  reg [3:0] px_code_r;
  reg [7:0] svc_code_r;
  reg [TMR_W-1:0] tmr_prev_r;
  reg busy_r;
  reg tmr_m_r;
  reg iot_m_r;
  reg per_m_r;
  reg [3:0] pm_r;
  reg [3:0] win;
  reg [11:0] pair;
  reg [7:0] code;
  reg px_masked;
  wire tmr_neg = timer_count[TMR_W-1];
  wire prev_neg = tmr_prev_r[TMR_W-1];
  wire prev_zero = (tmr_prev_r == {TMR_W{1'b0}});
  wire cur_zero = (timer_count == {TMR_W{1'b0}});
  wire prev_pos = !prev_neg && !prev_zero;
  wire tmr_edge = (MODEL_POS_TO_ZERO != 0) ?
    (prev_pos && (cur_zero || tmr_neg)) : (prev_zero && tmr_neg); // [R9]
  wire mca_set = prog_exc && prog_exception_mask && !hw_fault_mask; // [R3] [R21]
  wire mcr_src = hw_alarm || tabler_data_fault || tabler_control_word_fault;
  wire mcr_ok = !hw_fault_mask && !prog_exception_mask; // [R2] [R4] [R5]
  // only causes that actually raise a check reach the code
  wire [4:0] mc_new = {tabler_control_word_fault && mcr_ok, tabler_data_fault && mcr_ok,
    hw_alarm && mcr_ok, mca_set, hw_fault && !hw_fault_mask};

  assign event_id_lo = `ILPM_PER_ID_LO; // [R13]
  assign event_id_hi = `ILPM_PER_ID_HI; // [R13]
  assign pending = req_r;

  // program mask applies only to four classes
  always @* begin
    case (prog_exc_class)
      `ILPM_PX_FXOVF: px_masked = !pm_r[`ILPM_PM_FX]; // [R16]
      `ILPM_PX_DECOVF: px_masked = !pm_r[`ILPM_PM_DEC]; // [R16]
      `ILPM_PX_EXPUNF: px_masked = !pm_r[`ILPM_PM_EXP]; // [R16]
      `ILPM_PX_SIGNIF: px_masked = !pm_r[`ILPM_PM_SIG]; // [R16]
      default: px_masked = 1'b0;
    endcase
  end

  // request flip-flops; sets win over the entry clear
  always @* begin
    req_nxt = req_r;
    if (entry_done) begin
      req_nxt = 8'h00; // [R18]
    end
    if (hw_fault && !hw_fault_mask) begin
      req_nxt[1] = 1'b1; // [R1]
    end
    if (mca_set) begin
      req_nxt[2] = 1'b1; // [R3]
    end
    if (prog_exc && !prog_exception_mask && !hw_fault_mask && !px_masked) begin
      req_nxt[3] = 1'b1; // [R7] [R14]
    end
    if (supervisor_call) begin
      req_nxt[4] = 1'b1; // [R8]
    end
    if (event_trace_hit && event_trace_cr_en) begin
      req_nxt[5] = 1'b1; // [R13]
    end
    if (mcr_src && mcr_ok) begin
      req_nxt[6] = 1'b1; // [R2] [R4] [R5]
    end
    if (tmr_edge) begin
      req_nxt[7] = 1'b1; // [R9]
    end
    if (io_status_tabler_done || io_status_tabler_error) begin
      req_nxt[8] = 1'b1; // [R11]
    end
    // masked timer and tabler levels survive the clear and stay pending
    if (entry_done) begin
      req_nxt[7] = req_nxt[7] | (req_r[7] & !tmr_m_r); // [R10]
      req_nxt[8] = req_nxt[8] | (req_r[8] & !iot_m_r); // [R12]
    end
  end

  // winner: exigent any time, others only at boundary
  always @* begin
    win = `ILPM_LVL_NONE;
    if (req_r[1]) begin
      win = `ILPM_LVL_MCX; // [R19] [R26]
    end else if (instr_boundary) begin
      if (req_r[2]) begin
        win = `ILPM_LVL_MCA; // [R19]
      end else if (req_r[3]) begin
        win = `ILPM_LVL_PGM;
      end else if (req_r[4]) begin
        win = `ILPM_LVL_SVC; // [R24]
      end else if (req_r[5] && per_m_r) begin
        win = `ILPM_LVL_PER; // [R13]
      end else if (req_r[6]) begin
        win = `ILPM_LVL_MCR;
      end else if (req_r[7] && tmr_m_r) begin
        win = `ILPM_LVL_TMR; // [R10]
      end else if (req_r[8] && iot_m_r) begin
        win = `ILPM_LVL_IOT; // [R12]
      end
    end
  end

  // pair address and cause code per level
  always @* begin
    pair = `ILPM_PAIR_MC;
    code = {3'h0, mc_cause_r}; // [R6]
    case (win)
      `ILPM_LVL_PGM: begin
        pair = `ILPM_PAIR_PGM; // [R20]
        code = {4'h0, px_code_r}; // [R7]
      end
      `ILPM_LVL_SVC: begin
        pair = `ILPM_PAIR_SVC;
        code = svc_code_r;
      end
      `ILPM_LVL_PER: begin
        pair = `ILPM_PAIR_PER;
        code = `ILPM_CODE_ZERO;
      end
      `ILPM_LVL_TMR: begin
        pair = `ILPM_PAIR_TMR;
        code = `ILPM_CODE_TMR;
      end
      `ILPM_LVL_IOT: begin
        pair = `ILPM_PAIR_IOT;
        code = `ILPM_CODE_ZERO;
      end
      default: begin
        pair = `ILPM_PAIR_MC;
        code = {3'h0, mc_cause_r};
      end
    endcase
  end

  assign entry_req = (win != `ILPM_LVL_NONE) && !busy_r && !check_stop;
  assign entry_preempt = entry_req && (win == `ILPM_LVL_MCX); // [R1]

  always @(posedge clock) begin
    if (!nrst) begin
      req_r <= 8'h00; // [R25]
      hw_fault_mask <= 1'b0; // [R25]
      prog_exception_mask <= 1'b0; // [R25]
      check_stop <= 1'b0;
      mc_cause_r <= 5'h00;
      px_code_r <= 4'h0;
      svc_code_r <= 8'h00;
      tmr_prev_r <= {TMR_W{1'b0}};
      busy_r <= 1'b0;
      tmr_m_r <= 1'b0;
      iot_m_r <= 1'b0;
      per_m_r <= 1'b0;
      pm_r <= 4'h0;
      entry_level <= `ILPM_LVL_NONE;
      entry_pair_addr <= 12'h000;
      old_status_word <= 32'h00000000;
      event_id_store <= 1'b0;
    end else begin
      req_r <= req_nxt; // [R17]
      tmr_prev_r <= timer_count;
      event_id_store <= 1'b0;
      // causes accumulate so one check reports them all
      // cleared at entry end, but a cause arriving then still counts
      mc_cause_r <= (entry_done ? 5'h00 : mc_cause_r) | mc_new; // [R6]
      if (prog_exc) begin
        px_code_r <= prog_exc_class; // [R7]
      end
      if (supervisor_call) begin
        svc_code_r <= supervisor_call_code;
      end
      if (hw_fault_mask && (hw_fault || (prog_exc && prog_exception_mask))) begin
        check_stop <= 1'b1; // [R22] [R14]
      end
      if (entry_req) begin
        busy_r <= 1'b1;
        entry_level <= win;
        entry_pair_addr <= pair; // [R20]
        old_status_word <= {code, cur_program_status_word[23:0]}; // [R23]
        event_id_store <= (win == `ILPM_LVL_PER); // [R13]
        if (win == `ILPM_LVL_PGM) begin
          prog_exception_mask <= 1'b1; // [R21]
        end
        if ((win == `ILPM_LVL_MCX) || (win == `ILPM_LVL_MCA) ||
            (win == `ILPM_LVL_MCR)) begin
          hw_fault_mask <= 1'b1; // [R22]
        end
      end
      if (entry_done) begin
        busy_r <= 1'b0;
        // new masks take effect only once entry finishes
        tmr_m_r <= psw_timer_mask; // [R18]
        iot_m_r <= psw_tabler_mask;
        per_m_r <= psw_event_mask;
        pm_r <= psw_program_mask;
      end
      if (mask_clear_load) begin
        hw_fault_mask <= 1'b0;
        prog_exception_mask <= 1'b0;
      end
    end
  end
endmodule // ilpm_ctrl

// File: test/ilpm_ctrl_properties.sv
// Purpose: port-level checks on the interrupt selector
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every ilpm_ctrl instance
`include "ilpm_map.vh"
module ilpm_props (
  // clock and reset
  input wire clock,
  input wire nrst,
  // requests and handshake
  input wire hw_fault,
  input wire prog_exc,
  input wire supervisor_call,
  input wire instr_boundary,
  input wire mask_clear_load,
  // selector outputs
  input wire entry_req,
  input wire entry_preempt,
  input wire [3:0] entry_level,
  input wire [11:0] entry_pair_addr,
  input wire [11:0] event_id_lo,
  input wire hw_fault_mask,
  input wire prog_exception_mask,
  input wire check_stop,
  input wire [8:1] pending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // the reset edge itself must be watched, so no disable here
  reset_clear_a: assert property (disable iff (1'b0) !nrst |=> pending == 8'h00 &&
    !hw_fault_mask && !prog_exception_mask && !check_stop) else $error("reset left state");
  svc_held_a: assert property (supervisor_call && !hw_fault && !prog_exc && !check_stop
    && pending[3:1] == 3'h0 |=> pending[4]) else $error("call request lost");
  boundary_a: assert property (entry_req && !entry_preempt |-> instr_boundary)
    else $error("entry off boundary");
  preempt_a: assert property (entry_preempt |-> entry_req && pending[1])
    else $error("preempt without fault");
  take_once_a: assert property (entry_req |=> !entry_req) else $error("entry not taken");
  rank_one_a: assert property (entry_req && pending[1] |=>
    entry_level == `ILPM_LVL_MCX && hw_fault_mask) else $error("fault not first");
  pgm_mask_a: assert property (entry_req && pending[3] && pending[2:1] == 2'h0 |=>
    entry_level == `ILPM_LVL_PGM && prog_exception_mask) else $error("exception mask unset");
  svc_pair_a: assert property (entry_req ##1 entry_level == `ILPM_LVL_SVC |->
    entry_pair_addr == `ILPM_PAIR_SVC) else $error("call pair wrong");
  stop_a: assert property (check_stop |-> !entry_req) else $error("entry after stop");
  event_id_a: assert property (event_id_lo == `ILPM_PER_ID_LO) else $error("id area");
  mask_clear_a: assert property (mask_clear_load && !entry_req |=>
    !hw_fault_mask && !prog_exception_mask) else $error("masks not cleared");
endmodule // ilpm_props
bind ilpm_ctrl ilpm_props ilpm_props_i (.clock, .nrst, .hw_fault, .prog_exc, .supervisor_call,
  .instr_boundary, .mask_clear_load, .entry_req, .entry_preempt, .entry_level,
  .entry_pair_addr, .event_id_lo, .hw_fault_mask, .prog_exception_mask, .check_stop, .pending);

// File: test/ilpm_seq_model.sv
// Purpose: sequencer stand-in that finishes each entry sequence
// Assumes: entry taken on the edge where entry_req is high
// Notes: lat picks a prompt or slow answer
module ilpm_seq_model (
  // clock and reset
  input wire clock,
  input wire nrst,
  // handshake
  input wire entry_req,
  input wire [3:0] lat,
  output reg entry_done
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [4:0] cnt_r = 5'h00;
  initial entry_done = 1'h0;
  // falling edge keeps the pulse clear of the sampling edge
  always @(negedge clock) begin
    entry_done <= 1'h0;
    if (!nrst) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
      entry_done <= cnt_r == 5'h01;
    end else if (entry_req) begin
      cnt_r <= {1'h0, lat} + 5'h01;
    end
  end
endmodule // ilpm_seq_model

// File: test/ilpm_ctrl_bench.sv
// Purpose: self-checking bench for the interrupt selector
// Assumes: stimulus changes on the falling edge
// Notes: one task per scenario; stand-in closes entries
module ilpm_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg clock = 1'h0, nrst = 1'h0, hw_fault = 1'h0, hw_alarm = 1'h0, tabler_data_fault = 1'h0;
  reg tabler_control_word_fault = 1'h0, prog_exc = 1'h0, supervisor_call = 1'h0;
  reg io_status_tabler_done = 1'h0, io_status_tabler_error = 1'h0, event_trace_hit = 1'h0;
  reg event_trace_cr_en = 1'h1, psw_timer_mask = 1'h1, psw_tabler_mask = 1'h1;
  reg psw_event_mask = 1'h1, instr_boundary = 1'h1, mask_clear_load = 1'h0;
  reg [3:0] prog_exc_class = 4'h0, psw_program_mask = 4'h7, lat = 4'h0;
  reg [7:0] supervisor_call_code = 8'h00;
  reg [23:0] timer_count = 24'h000002;
  reg [31:0] cur_program_status_word = 32'h12345678;
  wire entry_req, entry_preempt, entry_done, hw_fault_mask, prog_exception_mask, check_stop;
  wire event_id_store;
  wire [11:0] event_id_lo, event_id_hi;
  wire [3:0] entry_level;
  wire [11:0] entry_pair_addr;
  wire [31:0] old_status_word;
  wire [8:1] pending;
  int errors = 0;
  int checks = 0;
  always #20 clock = ~clock;
  ilpm_ctrl #(.MODEL_POS_TO_ZERO(0), .TMR_W(24)) ilpm_ctrl_i (.clock, .nrst, .hw_fault,
    .hw_alarm, .tabler_data_fault, .tabler_control_word_fault, .prog_exc, .prog_exc_class,
    .supervisor_call, .supervisor_call_code, .timer_count, .io_status_tabler_done,
    .io_status_tabler_error, .event_trace_hit, .event_trace_cr_en, .psw_timer_mask,
    .psw_tabler_mask, .psw_event_mask, .psw_program_mask, .cur_program_status_word,
    .instr_boundary, .entry_done, .mask_clear_load, .entry_req, .entry_preempt, .entry_level,
    .entry_pair_addr, .old_status_word, .event_id_store, .event_id_lo, .event_id_hi,
    .hw_fault_mask, .prog_exception_mask, .check_stop, .pending);
  ilpm_seq_model ilpm_seq_model_i (.clock, .nrst, .entry_req, .lat, .entry_done);
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      errors++;
      $display("Error at %0t ns: %s", $time, m);
    end
  endtask
  // one edge passes, then every pulse input drops
  task automatic beat;
    @(negedge clock);
    {hw_fault, hw_alarm, tabler_data_fault, tabler_control_word_fault, prog_exc} = 5'h00;
    {supervisor_call, io_status_tabler_done, io_status_tabler_error} = 3'h0;
    {event_trace_hit, mask_clear_load} = 2'h0;
  endtask
  task automatic take(input [3:0] lvl, input [11:0] pair, input [7:0] code);
    int n;
    for (n = 0; n < 30 && entry_req !== 1'h1; n++) beat;
    beat;
    chk(entry_level === lvl && entry_pair_addr === pair, "level or pair wrong");
    chk(old_status_word === {code, cur_program_status_word[23:0]}, "old word wrong");
    chk(event_id_store === (lvl == 4'h5), "id store pulse wrong");
    for (n = 0; n < 30 && entry_done !== 1'h1; n++) beat;
    beat;
  endtask
  task automatic t_reset;
    nrst = 1'h0;
    repeat (8) beat;
    nrst = 1'h1;
    chk(entry_req === 1'h0 && pending === 8'h00 && check_stop === 1'h0, "reset state");
    chk(event_id_lo === 12'h1f0 && event_id_hi === 12'h1f7, "id area wrong");
  endtask
  task automatic t_unmask;
    mask_clear_load = 1'h1;
    beat;
    chk(hw_fault_mask === 1'h0 && prog_exception_mask === 1'h0, "masks stay set");
  endtask
  task automatic t_program;
    prog_exc = 1'h1;
    prog_exc_class = 4'h8;
    repeat (2) beat;
    chk(pending === 8'h00 && entry_req === 1'h0, "masked class raised");
    instr_boundary = 1'h0;
    cur_program_status_word = 32'h00abcdef;
    prog_exc = 1'h1;
    prog_exc_class = 4'h9;
    repeat (2) beat;
    chk(entry_req === 1'h0 && pending[3] === 1'h1, "entry inside instruction");
    instr_boundary = 1'h1;
    take(4'h3, 12'h040, 8'h09);
    chk(prog_exception_mask === 1'h1, "exception mask unset");
    prog_exc = 1'h1;
    take(4'h2, 12'h030, 8'h02);
    chk(hw_fault_mask === 1'h1, "check mask unset");
    t_unmask;
  endtask
  task automatic t_checks;
    lat = 4'h6;
    tabler_data_fault = 1'h1;
    take(4'h6, 12'h030, 8'h08);
    t_unmask;
    hw_alarm = 1'h1;
    tabler_control_word_fault = 1'h1;
    take(4'h6, 12'h030, 8'h14);
    t_unmask;
  endtask
  task automatic t_levels;
    timer_count = 24'h000000;
    repeat (2) beat;
    chk(pending[7] === 1'h0, "timer raised at zero");
    timer_count = 24'hffffff;
    take(4'h7, 12'h060, 8'h60);
    io_status_tabler_error = 1'h1;
    take(4'h8, 12'h020, 8'h00);
    io_status_tabler_done = 1'h1;
    take(4'h8, 12'h020, 8'h00);
    event_trace_hit = 1'h1;
    take(4'h5, 12'h080, 8'h00);
  endtask
  task automatic t_fault;
    lat = 4'h0;
    instr_boundary = 1'h0;
    hw_fault = 1'h1;
    beat;
    chk(entry_preempt === 1'h1, "fault waited for boundary");
    take(4'h1, 12'h030, 8'h01);
    hw_fault = 1'h1;
    repeat (2) beat;
    chk(check_stop === 1'h1 && entry_req === 1'h0, "second fault not stopped");
    instr_boundary = 1'h1;
    t_reset;
  endtask
  task automatic summarize;
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    summarize;
  end
  initial begin
    @(negedge clock);
    t_reset;
    supervisor_call = 1'h1;
    supervisor_call_code = 8'h5a;
    take(4'h4, 12'h050, 8'h5a);
    t_program;
    t_checks;
    t_levels;
    t_fault;
    summarize;
  end
endmodule // ilpm_ctrl_bench
